// ### pkg/sram_pkg.sv
// Purpose: Shared constants for the synchronous late-write SRAM port
// Assumes: One clock, synchronous active-high reset
// Notes:   Widths here are defaults; the top module may override some
package sram_pkg;
   localparam int DATA_W     = 72;    // Full data path
   localparam int LANE_W     = 9;     // One byte lane, parity included
   localparam int LANES      = 8;     // Byte lanes per word
   localparam int ADDR_W     = 19;    // Word address width
   localparam int BURST_W    = 2;     // Burst counter width
   localparam int FIFO_DEPTH = 8;     // Write commit buffer depth
   localparam int PIPE_RD_LAT = 2;    // Pipelined read latency
   localparam int FLOW_RD_LAT = 1;    // Flow-through read latency
   localparam logic [BURST_W-1:0] CNT_RST = 2'h0; // Counter after load
   localparam logic [DATA_W-1:0]  DOUT_RST = 72'h0; // Output data at reset

   // Power state of the core
   typedef enum logic [1:0] {
      ST_AWAKE,
      ST_SLEEP,
      ST_WAKE
   } pwr_state_e;
endpackage : sram_pkg

// ### verilog/sram_port.sv
// Purpose: Device-side logic of a synchronous SRAM with late write
// Assumes: Inputs synchronous to ref_clk_i except sleep and output enable
// Notes:   Writes retire through a small commit buffer into the array
`timescale 1ns/1ps
`default_nettype none

// Plain valid/ready FIFO, array plus wrapping pointers
module sram_commit_fifo #(
   parameter int W = 8,              // Word width
   parameter int D = 8               // Depth, power of two
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int PW = $clog2(D);
   logic [W-1:0] buf_mem [D];        // Storage words
   logic [PW:0]  wptr_ff;            // Write pointer with wrap bit
   logic [PW:0]  rptr_ff;            // Read pointer with wrap bit
   wire          empty = (wptr_ff == rptr_ff);
   wire          full  = (wptr_ff[PW-1:0] == rptr_ff[PW-1:0]) &&
                         (wptr_ff[PW] != rptr_ff[PW]);
   wire          push  = in_valid_i && !full;
   wire          pop   = out_valid_o && out_ready_i;

   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = buf_mem[rptr_ff[PW-1:0]];

   // Pointers
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
      end else begin
         if (push) wptr_ff <= wptr_ff + 1'b1;
         if (pop)  rptr_ff <= rptr_ff + 1'b1;
      end
   end

   // Storage, no reset needed
   always_ff @(posedge ref_clk_i) begin
      if (push) buf_mem[wptr_ff[PW-1:0]] <= in_data_i;
   end
endmodule : sram_commit_fifo

module sram_port #(
   parameter int ADDR_W     = sram_pkg::ADDR_W,     // Word address width
   parameter int FIFO_DEPTH = sram_pkg::FIFO_DEPTH  // Commit buffer depth
) (
   input  wire logic                        ref_clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        clk_gate_n_i,
   input  wire logic                        chip_select_one_n_i,
   input  wire logic                        chip_select_two_i,
   input  wire logic                        chip_select_three_n_i,
   input  wire logic                        write_enable_n_i,
   input  wire logic                        advance_not_load_i,
   input  wire logic [sram_pkg::LANES-1:0]  byte_write_n_i,
   input  wire logic [ADDR_W-1:0]           address_i,
   input  wire logic [sram_pkg::DATA_W-1:0] data_lane_i,
   output logic      [sram_pkg::DATA_W-1:0] data_lane_o,
   output logic                             data_lane_oe_o,
   input  wire logic                        output_enable_n_i,
   input  wire logic                        sleep_request_i,
   input  wire logic                        flow_through_select_n_i,
   input  wire logic                        burst_order_select_n_i,
   output logic                             write_buffer_ready_o,
   output logic                             sleep_status_o
);
   import sram_pkg::*;

   localparam int FW = ADDR_W + LANES + DATA_W; // Buffer word

   // Next low address bits of a burst
   function automatic logic [BURST_W-1:0] step_low(
      input logic [BURST_W-1:0] base,
      input logic [BURST_W-1:0] cnt,
      input logic               linear
   );
      step_low = linear ? BURST_W'(base + cnt) : (base ^ cnt);
   endfunction : step_low

   logic [DATA_W-1:0] mem [2**ADDR_W];  // Storage array
   pwr_state_e        pwr_ff;           // Power state
   pwr_state_e        nxt_pwr;
   logic [ADDR_W-1:0] base_ff;          // Loaded burst address
   logic [BURST_W-1:0] cnt_ff;          // Beats since load
   logic              burst_act_ff;     // Burst may continue
   logic              burst_wr_ff;      // Burst is a write
   logic              rd1_v_ff;         // Pipelined read in flight
   logic [DATA_W-1:0] rd1_d_ff;         // Output register stage
   logic              drive_ff;         // Pipeline wants the bus
   logic [DATA_W-1:0] dout_ff;          // Data on the pins
   logic              w1_v_ff;          // Write one edge old
   logic [ADDR_W-1:0] w1_a_ff;
   logic [LANES-1:0]  w1_be_ff;
   logic              w2_v_ff;          // Write two edges old
   logic [ADDR_W-1:0] w2_a_ff;
   logic [LANES-1:0]  w2_be_ff;
   logic              wbr_ff;           // Buffer ready, registered
   logic              slp_ff;           // Sleep status, registered

   // Command decode
   wire selected   = !chip_select_one_n_i && chip_select_two_i &&
                     !chip_select_three_n_i;
   wire suspend    = clk_gate_n_i;
   wire pipe_mode  = flow_through_select_n_i;
   wire linear     = !burst_order_select_n_i;
   wire live       = !suspend && (pwr_ff == ST_AWAKE);
   wire load_cmd   = live && !advance_not_load_i;
   wire burst_step = live && advance_not_load_i && burst_act_ff;
   wire rd_fire    = (load_cmd && selected && write_enable_n_i) ||
                     (burst_step && !burst_wr_ff);
   wire wr_fire    = (load_cmd && selected && !write_enable_n_i) ||
                     (burst_step && burst_wr_ff);

   // Address of this beat, counter steps by the selected order
   wire [BURST_W-1:0] cnt_inc = BURST_W'(cnt_ff + 1'b1);
   wire [BURST_W-1:0] low_nxt = step_low(base_ff[BURST_W-1:0],
                                         cnt_inc, linear);
   wire [ADDR_W-1:0] cur_addr = load_cmd ? address_i :
                                {base_ff[ADDR_W-1:BURST_W], low_nxt};
   wire [DATA_W-1:0] rd_q = mem[cur_addr];

   // Late write data taken per mode
   wire              wr_take = !suspend &&
                               (pipe_mode ? w2_v_ff : w1_v_ff);
   wire [ADDR_W-1:0] take_a  = pipe_mode ? w2_a_ff : w1_a_ff;
   wire [LANES-1:0]  take_be = pipe_mode ? w2_be_ff : w1_be_ff;
   wire              push_v  = wr_take && (|take_be); // No-op if no lane

   // Commit buffer between the pins and the array
   wire              fifo_in_ready;
   wire              fifo_out_valid;
   wire [FW-1:0]     fifo_out_data;
   // Drain waits for array reads, suspend and sleep: one array port
   wire              drain_ready = !rd_fire && !suspend &&
                                   (pwr_ff != ST_SLEEP);
   wire              drain = fifo_out_valid && drain_ready;
   wire [ADDR_W-1:0] dr_a  = fifo_out_data[FW-1 -: ADDR_W];
   wire [LANES-1:0]  dr_be = fifo_out_data[DATA_W +: LANES];
   wire [DATA_W-1:0] dr_d  = fifo_out_data[DATA_W-1:0];
   wire [DATA_W-1:0] old_w = mem[dr_a];
   wire [DATA_W-1:0] merged;

   sram_commit_fifo #(
      .W (FW),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (push_v),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({take_a, take_be, data_lane_i}),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (drain_ready),
      .out_data_o  (fifo_out_data)
   );

   // Lane merge, untouched lanes keep old contents
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign merged[g*LANE_W +: LANE_W] = dr_be[g] ?
             dr_d[g*LANE_W +: LANE_W] :
             old_w[g*LANE_W +: LANE_W];
   end

   // Self-timed array write, no pulse from outside
   always_ff @(posedge ref_clk_i) begin
      if (drain) mem[dr_a] <= merged;
   end

   // Power state; wake waits for the buffer to empty
   always_comb begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         ST_AWAKE: if (sleep_request_i) nxt_pwr = ST_SLEEP;
         ST_SLEEP: if (!sleep_request_i) nxt_pwr = ST_WAKE;
         ST_WAKE: begin
            if (sleep_request_i)      nxt_pwr = ST_SLEEP;
            else if (!fifo_out_valid) nxt_pwr = ST_AWAKE;
         end
         default: nxt_pwr = ST_SLEEP;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pwr_ff <= ST_AWAKE;
         slp_ff <= 1'b0;
         wbr_ff <= 1'b1;
      end else begin
         pwr_ff <= nxt_pwr;
         slp_ff <= (nxt_pwr != ST_AWAKE);
         wbr_ff <= fifo_in_ready;
      end
   end

   // Burst address tracking
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         base_ff      <= '0;
         cnt_ff       <= CNT_RST;
         burst_act_ff <= 1'b0;
         burst_wr_ff  <= 1'b0;
      end else if (load_cmd) begin
         base_ff      <= address_i;
         cnt_ff       <= CNT_RST;
         burst_act_ff <= selected;  // Deselect ends any burst
         burst_wr_ff  <= !write_enable_n_i;
      end else if (burst_step) begin
         cnt_ff <= cnt_inc;
      end
   end

   // Read path; suspend freezes every stage
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rd1_v_ff <= 1'b0;
         rd1_d_ff <= DOUT_RST;
         drive_ff <= 1'b0;
         dout_ff  <= DOUT_RST;
      end else if (!suspend) begin
         rd1_v_ff <= rd_fire && pipe_mode;
         rd1_d_ff <= rd_q;
         if (pipe_mode) begin
            drive_ff <= rd1_v_ff;
            dout_ff  <= rd1_d_ff;
         end else begin
            drive_ff <= rd_fire;
            dout_ff  <= rd_q;
         end
      end
   end

   // Write descriptor pipeline
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         w1_v_ff <= 1'b0;
         w2_v_ff <= 1'b0;
      end else if (!suspend) begin
         w1_v_ff <= wr_fire;
         w2_v_ff <= w1_v_ff;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!suspend) begin
         w1_a_ff  <= cur_addr;
         w1_be_ff <= ~byte_write_n_i;
         w2_a_ff  <= w1_a_ff;
         w2_be_ff <= w1_be_ff;
      end
   end

   // Outputs; the enable is gated without the clock by design
   assign data_lane_o          = dout_ff;
   assign data_lane_oe_o       = drive_ff && !output_enable_n_i &&
                                 !sleep_request_i;
   assign write_buffer_ready_o = wbr_ff;
   assign sleep_status_o       = slp_ff;

   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   property p_oe_override;
      output_enable_n_i |-> !data_lane_oe_o;
   endproperty
   a_oe_override: assert property (p_oe_override)
      else $error("drivers on while output enable off");

   property p_sleep_off;
      sleep_request_i |-> !data_lane_oe_o ##1 sleep_status_o;
   endproperty
   a_sleep_off: assert property (p_sleep_off)
      else $error("sleep did not quiet the device");

   property p_flow_read;
      rd_fire && !pipe_mode |=> drive_ff && data_lane_o == $past(rd_q);
   endproperty
   a_flow_read: assert property (p_flow_read)
      else $error("flow-through read data late or wrong");

   property p_pipe_read;
      rd_fire && pipe_mode ##1 !suspend && pipe_mode |=>
         drive_ff && data_lane_o == $past(rd1_d_ff);
   endproperty
   a_pipe_read: assert property (p_pipe_read)
      else $error("pipelined read not two edges");

   property p_suspend_hold;
      suspend |=> $stable(data_lane_o) && $stable(drive_ff) &&
                  $stable(cnt_ff);
   endproperty
   a_suspend_hold: assert property (p_suspend_hold)
      else $error("state moved while clock gated");

   property p_wr_pipe;
      wr_fire && pipe_mode ##1 !suspend |=> (!suspend && pipe_mode) |-> wr_take;
   endproperty
   a_wr_pipe: assert property (p_wr_pipe)
      else $error("double late write data not taken");

   property p_wr_flow;
      wr_fire && !pipe_mode |=> (!suspend && !pipe_mode) |-> wr_take;
   endproperty
   a_wr_flow: assert property (p_wr_flow)
      else $error("single late write data not taken");

   property p_burst_lin;
      burst_step && linear |->
         cur_addr[1:0] == 2'(base_ff[1:0] + cnt_ff + 2'h1);
   endproperty
   a_burst_lin: assert property (p_burst_lin)
      else $error("linear burst address wrong");

   property p_burst_ilv;
      burst_step && !linear |->
         cur_addr[1:0] == (base_ff[1:0] ^ 2'(cnt_ff + 2'h1));
   endproperty
   a_burst_ilv: assert property (p_burst_ilv)
      else $error("interleaved burst address wrong");

   property p_no_dead;
      load_cmd && selected |-> rd_fire || wr_fire;
   endproperty
   a_no_dead: assert property (p_no_dead)
      else $error("selected load did not start access");

   c_rd_wr: cover property (rd_fire ##1 wr_fire ##1 rd_fire);
   c_burst: cover property (burst_step [*3]);
   c_full:  cover property (!fifo_in_ready);
endmodule : sram_port
`default_nettype wire

// ### test/sram_host_model.sv
// Purpose: Memory controller stand-in that supplies late write data
// Assumes: Bench raises wr_cmd_i with every write command it issues while the device is selected
// Notes:   Outside write beats the data bus toggles like a released bus
`timescale 1ns/1ps
`default_nettype none
module sram_host_model
   import sram_pkg::*;
(
   input  wire logic                        ref_clk_i,
   input  wire logic                        clk_gate_n_i,
   input  wire logic                        flow_through_select_n_i,
   input  wire logic                        wr_cmd_i,
   input  wire logic [sram_pkg::DATA_W-1:0] wr_data_i,
   output logic      [sram_pkg::DATA_W-1:0] data_lane_o
);
   logic              cmd_s, gate_s, v1, v2; // Sampled inputs, stage valids
   logic [DATA_W-1:0] dat_s, d1, d2;         // Sampled and staged data

   initial begin
      v1 = 1'h0;
      v2 = 1'h0;
      data_lane_o = '0;
   end

   // Sample at the edge first: the bench changes its pins 1 ns later
   always @(posedge ref_clk_i) begin
      cmd_s = wr_cmd_i;
      dat_s = wr_data_i;
      gate_s = clk_gate_n_i;
      #1;
      // Suspended edges do not advance the write pipeline
      if (!gate_s) begin
         v2 = v1;
         d2 = d1;
         v1 = cmd_s;
         d1 = dat_s;
      end
      // Data stands for the edge two (pipelined) or one (flow) later
      if (flow_through_select_n_i ? v2 : v1)
         data_lane_o = flow_through_select_n_i ? d2 : d1;
      else // Never leave a stale word that a faulty design could take
         data_lane_o = ~data_lane_o;
   end
endmodule : sram_host_model
`default_nettype wire

// ### test/sync_no_turnaround_sram_port_bench.sv
// Purpose: Self-checking bench for the late-write SRAM port
// Assumes: ADDR_W cut to 8; reads never chase a still-buffered write
// Notes:   One write per cycle at most, so the buffer cannot be filled
`timescale 1ns/1ps
`default_nettype none
module sync_no_turnaround_sram_port_bench;
   import sram_pkg::*;
   localparam int AW = 8; // Small array for simulation
   logic              ref_clk_i, rst_i, clk_gate_n_i, write_enable_n_i, advance_not_load_i;
   logic              chip_select_one_n_i, chip_select_two_i, chip_select_three_n_i;
   logic              output_enable_n_i, sleep_request_i, flow_through_select_n_i, burst_order_select_n_i;
   logic              data_lane_oe_o, write_buffer_ready_o, sleep_status_o, wr_cmd, g, due, bsel;
   logic [LANES-1:0]  byte_write_n_i;
   logic [AW-1:0]     address_i, bbase;
   logic [DATA_W-1:0] data_lane_i, data_lane_o, wr_data;
   logic [DATA_W-1:0] mem [int];     // Reference contents
   logic [DATA_W-1:0] exp_d [$];     // Expected read words
   int                exp_t [$];     // Edge count each word is due
   int                ecnt, lat, errors, checked;
   logic [1:0]        bn;            // Burst beat

   sram_port #(.ADDR_W(AW), .FIFO_DEPTH(FIFO_DEPTH)) sram_port_i (.ref_clk_i, .rst_i, .clk_gate_n_i,
      .chip_select_one_n_i, .chip_select_two_i, .chip_select_three_n_i, .write_enable_n_i,
      .advance_not_load_i, .byte_write_n_i, .address_i, .data_lane_i, .data_lane_o, .data_lane_oe_o,
      .output_enable_n_i, .sleep_request_i, .flow_through_select_n_i, .burst_order_select_n_i,
      .write_buffer_ready_o, .sleep_status_o);
   sram_host_model sram_host_model_i (.ref_clk_i, .clk_gate_n_i, .flow_through_select_n_i,
      .wr_cmd_i(wr_cmd), .wr_data_i(wr_data), .data_lane_o(data_lane_i));

   initial begin
      ref_clk_i = 1'h0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // Count unsuspended edges; read latency is measured in these
   always @(posedge ref_clk_i)
      if (rst_i) ecnt <= 0;
      else if (!clk_gate_n_i) ecnt <= ecnt + 1;

   task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : cmp

   // Drive enable and read data checked after every unsuspended edge out of reset, settled by 2 ns
   always @(posedge ref_clk_i) begin
      g = clk_gate_n_i;
      #2;
      if (!g && !rst_i) begin
         due = exp_t.size() > 0 && exp_t[0] == ecnt;
         cmp(data_lane_oe_o, due && !output_enable_n_i && !sleep_request_i, "drive enable");
         if (due) begin
            cmp(data_lane_o, exp_d.pop_front(), "read data");
            void'(exp_t.pop_front());
         end
      end
   end

   function automatic logic [DATA_W-1:0] pat(input int k);
      return DATA_W'(k) * 72'h01_0203_0405_0607_0809 + 72'h5a;
   endfunction : pat

   task automatic idle(input int n);
      chip_select_one_n_i = 1'h1;
      advance_not_load_i = 1'h0;
      wr_cmd = 1'h0;
      repeat (n) @(posedge ref_clk_i) #1;
      chip_select_one_n_i = 1'h0; // Selected again, next command needs no setup
   endtask : idle

   // One command cycle; adv continues the burst of the last load
   task automatic op(input logic wr, input int a, input logic [7:0] be_n, input logic [DATA_W-1:0] d,
                     input logic advance_not_load);
      logic [AW-1:0] ea;
      if (!advance_not_load) begin
         bbase = a[AW-1:0];
         bn = 2'h0;
         bsel = !chip_select_one_n_i && chip_select_two_i && !chip_select_three_n_i;
      end else bn++;
      ea = {bbase[AW-1:2], burst_order_select_n_i ? bbase[1:0] ^ bn : bbase[1:0] + bn};
      write_enable_n_i = !wr;
      advance_not_load_i = advance_not_load;
      address_i = a[AW-1:0];
      byte_write_n_i = be_n;
      wr_cmd = wr && bsel;
      wr_data = d;
      if (bsel && !sleep_request_i && !sleep_status_o) begin
         if (!wr) begin
            exp_t.push_back(ecnt + lat);
            exp_d.push_back(mem[ea]);
         end else
            for (int l = 0; l < LANES; l++)
               if (!be_n[l]) mem[ea][l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
      end
      @(posedge ref_clk_i) #1;
   endtask : op

   task automatic do_reset;
      rst_i = 1'h1;
      idle(5);
      rst_i = 1'h0;
      exp_t.delete();
      exp_d.delete();
      lat = flow_through_select_n_i ? PIPE_RD_LAT : FLOW_RD_LAT;
      cmp({data_lane_oe_o, sleep_status_o, write_buffer_ready_o}, 3'h1, "reset outputs");
   endtask : do_reset

   // All scenarios for the current mode pins
   task automatic traffic;
      for (int i = 0; i < 8; i++) op(1, i, 8'h00, pat(i), 0);
      idle(4);
      for (int i = 0; i < 8; i++) begin
         op(1, 16 + i, 8'h00, pat(16 + i), 0);
         op(0, i, 8'hff, 72'h0, 0);
      end
      op(1, 2, 8'h5a, ~pat(2), 0);
      op(1, 3, 8'hff, 72'h0, 0);
      // Drop each select in turn: neither write nor read may act
      for (int s = 0; s < 3; s++) begin
         chip_select_one_n_i = (s == 0);
         chip_select_two_i = (s != 1);
         chip_select_three_n_i = (s == 2);
         op(1, 4, 8'h00, 72'h0, 0);
         op(0, 4, 8'hff, 72'h0, 0);
      end
      chip_select_two_i = 1'h1;
      chip_select_three_n_i = 1'h0;
      idle(4);
      for (int i = 2; i < 5; i++) op(0, i, 8'hff, 72'h0, 0);
      op(0, 17, 8'hff, 72'h0, 0);
      repeat (3) op(0, 0, 8'hff, 72'h0, 1);
      op(0, 6, 8'hff, 72'h0, 0);
      clk_gate_n_i = 1'h1;
      idle(3);
      clk_gate_n_i = 1'h0;
      idle(3);
      // Async overrides halfway between edges, while a word is out
      op(0, 5, 8'hff, 72'h0, 0);
      idle(lat - 1);
      #1.5 output_enable_n_i = 1'h1;
      #0.5 cmp(data_lane_oe_o, 72'h0, "enable override");
      output_enable_n_i = 1'h0;
      sleep_request_i = 1'h1;
      #0.5 cmp(data_lane_oe_o, 72'h0, "sleep override");
      sleep_request_i = 1'h0;
      #0.5 cmp(data_lane_oe_o, 72'h1, "drive restored");
      sleep_request_i = 1'h1;
      idle(2);
      cmp(sleep_status_o, 72'h1, "asleep");
      op(0, 7, 8'hff, 72'h0, 0);
      idle(1);
      sleep_request_i = 1'h0;
      for (int k = 0; k < 40 && sleep_status_o !== 1'h0; k++) idle(1);
      cmp(sleep_status_o, 72'h0, "awake");
   endtask : traffic

   task automatic wrap_up;
      if (errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up

   // Whole run is under 200 cycles; 20000 cycles means a hang
   initial begin
      #100000;
      errors++;
      wrap_up();
   end

   initial begin
      {rst_i, clk_gate_n_i, write_enable_n_i, advance_not_load_i, chip_select_one_n_i} = 5'h05;
      {chip_select_two_i, chip_select_three_n_i, output_enable_n_i, sleep_request_i, wr_cmd} = 5'h10;
      {byte_write_n_i, address_i, wr_data, errors, checked} = '0;
      // Mode pins change only under reset, held static meanwhile
      for (int m = 0; m < 2; m++) begin
         flow_through_select_n_i = !m[0];
         burst_order_select_n_i = m[0];
         do_reset();
         traffic();
      end
      idle(8);
      cmp(write_buffer_ready_o, 72'h1, "buffer ready");
      wrap_up();
   end
endmodule : sync_no_turnaround_sram_port_bench
`default_nettype wire
